// ### rtl/rcm_cmd_core.sv
// Design decisions made here: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "rcm_defs.svh"
module rcm_cmd_core (
  // clock and reset
  input  wire logic               clk_sys,
  input  wire logic               rst_n,
  // register port
  input  wire rcm_pkg::rcm_addr_t reg_addr,
  input  wire rcm_pkg::rcm_word_t reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic [15:0]             reg_rdata,
  // incoming frame from mac side
  input  wire logic               frame_valid,
  input  wire logic [1:0]         frame_port,
  input  wire logic [15:0]        frame_len,
  input  wire logic               frame_err,
  input  wire logic               frame_monitor,
  input  wire logic [15:0]        frame_type,
  input  wire logic [47:0]        frame_src,
  output logic                    frame_drop,
  // data mover request
  output logic                    dma_start,
  output logic [31:0]             dma_addr,
  output logic [15:0]             dma_len,
  // completion posting
  output logic                    post_valid,
  input  wire logic               post_ready,
  output logic                    post_group,
  output rcm_pkg::rcm_mask_t      post_mask,
  output rcm_pkg::rcm_word_t      post_status,
  output rcm_pkg::rcm_word_t      post_size,
  output rcm_pkg::rcm_word_t      post_type,
  output logic [47:0]             post_src,
  output logic                    post_irq,
  output logic [7:0]              post_irq_level,
  output logic [7:0]              post_irq_vector
);
  import rcm_pkg::*;
  localparam int NP = 8;
  // staged command block words
  rcm_word_t cmd_q [18];
  // pool of receive commands
  rcm_mask_t  pv_q, pd_q, pe_q, any_q, sro_q, irq_allow_q;
  logic [1:0] port_q  [NP];
  rcm_word_t  nirq_q  [NP];
  rcm_word_t  eirq_q  [NP];
  logic [31:0] badr_q [NP];
  rcm_word_t  size_q  [NP];
  rcm_word_t  type_q  [NP];
  logic [47:0] srca_q [NP];
  // grouped completion configuration
  logic       grp_on_q, girq_on_q;
  rcm_word_t  girq_q, maxcnt_q, last_st_q, drops_q;
  rcm_post_e  pst_q;
  logic [15:0] rdata_q;

  // command decode on submit
  logic       submit, master, is_recv, is_init, port_ok;
  logic [3:0] opt_port;
  always_comb
  begin
    submit   = reg_wr && (reg_addr == `RCM_REG_SUBMIT);
    master   = reg_wdata[0];
    is_recv  = cmd_q[`RCM_W_CODE] == `RCM_CODE_RECV;
    is_init  = cmd_q[`RCM_W_CODE] == `RCM_CODE_GINIT;
    opt_port = cmd_q[`RCM_W_OPT][`RCM_OPT_PORT_HI:`RCM_OPT_PORT_LO];
    port_ok  = opt_port <= `RCM_PORT_MAX;
  end

  // per-entry candidate masks for a new command and a frame
  rcm_mask_t free_m, own_m, any_m;
  genvar g;
  generate
    for (g = 0; g < NP; g++)
    begin : g_match
      assign free_m[g] = !pv_q[g];
      assign own_m[g]  = pv_q[g] && !pd_q[g] && !any_q[g] && (port_q[g] == frame_port);
      assign any_m[g]  = pv_q[g] && !pd_q[g] && any_q[g];
    end
  endgenerate
  function automatic rcm_idx_t first_one(input rcm_mask_t m);
    first_one = 3'h0;
    for (int i = NP - 1; i >= 0; i--)
      if (m[i])
        first_one = i[2:0];
  endfunction
  // frame buffer choice: own port first, pool second
  logic     frm_hit, frm_own;
  rcm_idx_t frm_idx, free_idx;
  logic [15:0] xfer;
  always_comb
  begin
    frm_own  = |own_m;
    frm_hit  = frame_valid && (frm_own || (|any_m));
    frm_idx  = frm_own ? first_one(own_m) : first_one(any_m);
    free_idx = first_one(free_m);
    // clip to host limit; monitor reports move no data
    if (frame_monitor)
      xfer = 16'h0000;
    else if (frame_len > size_q[frm_idx])
      xfer = size_q[frm_idx];
    else
      xfer = frame_len;
  end

  // posting selection: groups of eligible, else lowest lone entry
  rcm_mask_t elig_m, grp_m;
  logic [3:0] grp_n;
  logic      grp_go;
  rcm_idx_t  one_idx;
  always_comb
  begin
    elig_m = pd_q & ~pe_q & ~sro_q;
    grp_m  = 8'h00;
    grp_n  = 4'h0;
    for (int i = 0; i < NP; i++)
    begin
      if (elig_m[i] && ({12'h000, grp_n} < maxcnt_q))
      begin
        grp_m[i] = 1'b1;
        grp_n    = grp_n + 4'h1;
      end
    end
    grp_go  = grp_on_q && (grp_n >= 4'h2);
    one_idx = first_one(pd_q);
  end
  // staging window for command block words
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < 18; i++)
        cmd_q[i] <= 16'h0000;
    end
    else if (reg_wr && (reg_addr <= {3'h0, `RCM_W_LAST}))
      cmd_q[reg_addr[4:0]] <= reg_wdata;
  end
  // grouped completion setup, master slot only
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      grp_on_q  <= 1'b0;
      girq_on_q <= 1'b0;
      girq_q    <= `RCM_GIRQ_RST;
      maxcnt_q  <= `RCM_MAXCNT_RST;
    end
    else if (submit && is_init && master)
    begin
      grp_on_q  <= cmd_q[`RCM_W_CTRL][`RCM_CTL_GRP];
      girq_on_q <= cmd_q[`RCM_W_CTRL][`RCM_CTL_GIRQ];
      girq_q    <= cmd_q[`RCM_W_GIRQ];
      maxcnt_q  <= cmd_q[`RCM_W_MAXCNT];
      // minimum group count word never read
    end
  end

  // return status of the last submitted command
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      last_st_q <= `RCM_ST_OK;
    else if (submit)
    begin
      if (is_init)
        last_st_q <= master ? `RCM_ST_OK : `RCM_ST_BADSLOT;
      else if (!is_recv)
        last_st_q <= `RCM_ST_BADCODE;
      else if (!port_ok)
        last_st_q <= `RCM_ST_BADPORT;
      else if (&pv_q)
        last_st_q <= `RCM_ST_FULL;
      else
        last_st_q <= `RCM_ST_OK;
    end
  end

  // receive pool: fill on submit, update on frame, free on post
  logic accept, retire;
  assign accept = submit && is_recv && port_ok && !(&pv_q);
  assign retire = post_valid && post_ready;
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pv_q  <= 8'h00;
      pd_q  <= 8'h00;
      pe_q  <= 8'h00;
      any_q <= 8'h00;
      sro_q <= 8'h00;
      irq_allow_q <= 8'h00;
      for (int i = 0; i < NP; i++)
      begin
        port_q[i] <= 2'h0;
        nirq_q[i] <= 16'h0000;
        eirq_q[i] <= 16'h0000;
        badr_q[i] <= 32'h0000_0000;
        size_q[i] <= 16'h0000;
        type_q[i] <= 16'h0000;
        srca_q[i] <= 48'h0000_0000_0000;
      end
    end
    else
    begin
      // retired entries go first; a new frame never picks them
      if (retire)
      begin
        pv_q <= pv_q & ~post_mask;
        pd_q <= pd_q & ~post_mask;
      end
      if (accept)
      begin
        pv_q[free_idx]   <= 1'b1;
        pd_q[free_idx]   <= 1'b0;
        pe_q[free_idx]   <= 1'b0;
        any_q[free_idx]  <= cmd_q[`RCM_W_OPT][`RCM_OPT_ANY];
        sro_q[free_idx]  <= cmd_q[`RCM_W_OPT][`RCM_OPT_SRO];
        irq_allow_q[free_idx] <= cmd_q[`RCM_W_OPT][`RCM_OPT_IRQ_ALLOW];
        port_q[free_idx] <= opt_port[1:0];
        nirq_q[free_idx] <= cmd_q[`RCM_W_NIRQ];
        eirq_q[free_idx] <= cmd_q[`RCM_W_EIRQ];
        badr_q[free_idx] <= {cmd_q[`RCM_W_ADDR_HI], cmd_q[`RCM_W_ADDR_LO]};
        size_q[free_idx] <= cmd_q[`RCM_W_MAXSZ];
        type_q[free_idx] <= 16'h0000;
        srca_q[free_idx] <= 48'h0000_0000_0000;
      end
      if (frm_hit)
      begin
        pd_q[frm_idx]   <= 1'b1;
        pe_q[frm_idx]   <= frame_err;
        size_q[frm_idx] <= xfer + `RCM_SIZE_PAD;
        if (frame_monitor)
        begin
          type_q[frm_idx] <= frame_type;
          srca_q[frm_idx] <= frame_src;
        end
      end
    end
  end

  // data mover request and drop indication
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dma_start  <= 1'b0;
      dma_addr   <= 32'h0000_0000;
      dma_len    <= 16'h0000;
      frame_drop <= 1'b0;
      drops_q    <= 16'h0000;
    end
    else
    begin
      dma_start  <= frm_hit && !frame_monitor && !frame_err;
      frame_drop <= frame_valid && !frm_hit;
      if (frm_hit)
      begin
        dma_addr <= badr_q[frm_idx];
        dma_len  <= xfer;
      end
      if (frame_valid && !frm_hit)
        drops_q <= drops_q + 16'h0001;
    end
  end

  // posting engine: hold one completion until taken
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pst_q           <= RCM_IDLE;
      post_group      <= 1'b0;
      post_mask       <= 8'h00;
      post_status     <= 16'h0000;
      post_size       <= 16'h0000;
      post_type       <= 16'h0000;
      post_src        <= 48'h0000_0000_0000;
      post_irq        <= 1'b0;
      post_irq_level  <= 8'h00;
      post_irq_vector <= 8'h00;
    end
    else
    begin
      case (pst_q)
        RCM_IDLE:
        begin
          if (grp_go)
          begin
            pst_q           <= RCM_HOLD;
            post_group      <= 1'b1;
            post_mask       <= grp_m;
            post_status     <= `RCM_ST_OK;
            post_size       <= {12'h000, grp_n};
            post_type       <= 16'h0000;
            post_src        <= 48'h0000_0000_0000;
            post_irq        <= girq_on_q;
            post_irq_level  <= girq_q[15:8];
            post_irq_vector <= girq_q[7:0];
          end
          else if (|pd_q)
          begin
            // whatever cannot group goes alone; a cap below two must not stall
            pst_q           <= RCM_HOLD;
            post_group      <= 1'b0;
            post_mask       <= 8'h01 << one_idx;
            post_status     <= pe_q[one_idx] ? `RCM_ST_FRMERR : `RCM_ST_OK;
            post_size       <= size_q[one_idx];
            post_type       <= type_q[one_idx];
            post_src        <= srca_q[one_idx];
            post_irq        <= irq_allow_q[one_idx];
            post_irq_level  <= pe_q[one_idx] ? eirq_q[one_idx][15:8] : nirq_q[one_idx][15:8];
            post_irq_vector <= pe_q[one_idx] ? eirq_q[one_idx][7:0] : nirq_q[one_idx][7:0];
          end
        end
        RCM_HOLD:
        begin
          if (post_ready)
            pst_q <= RCM_IDLE;
        end
        default:
          pst_q <= RCM_IDLE;
      endcase
    end
  end
  assign post_valid = (pst_q == RCM_HOLD);

  // register reads: data stand only in the cycle after the strobe
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      rdata_q <= 16'h0000;
    else if (!reg_rd)
      rdata_q <= 16'h0000;
    else if (reg_addr <= {3'h0, `RCM_W_LAST})
      rdata_q <= cmd_q[reg_addr[4:0]];
    else
    begin
      case (reg_addr)
        `RCM_REG_STATUS: rdata_q <= {pd_q, pv_q};
        `RCM_REG_LASTST: rdata_q <= last_st_q;
        `RCM_REG_GCFG:   rdata_q <= {14'h0000, girq_on_q, grp_on_q};
        `RCM_REG_DROPS:  rdata_q <= drops_q;
        default:         rdata_q <= 16'h0000;
      endcase
    end
  end
  assign reg_rdata = rdata_q;

  // checks on setup, pool and posting
  sequence s_init_master;
    submit && is_init && master;
  endsequence
  sequence s_recv_ok;
    submit && is_recv && port_ok && !(&pv_q);
  endsequence
  recv_accept_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_recv_ok |=> (last_st_q == `RCM_ST_OK) && ($countones(pv_q) > $countones($past(pv_q)))
      || $past(retire))
    else $error("receive command not taken into pool");
  bad_port_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    submit && is_recv && !port_ok |=> last_st_q == `RCM_ST_BADPORT)
    else $error("port above 3 not refused");
  group_enable_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_init_master ##1 1'b1 |-> grp_on_q == $past(cmd_q[`RCM_W_CTRL][0]))
    else $error("grouping flag not taken from control bit 0");
  init_slot_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    submit && is_init && !master |=> $stable(grp_on_q) && last_st_q == `RCM_ST_BADSLOT)
    else $error("group init accepted outside master slot");
  group_min_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    post_valid && post_group |-> $countones(post_mask) >= 2)
    else $error("group holds fewer than two commands");
  group_clean_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(post_valid) && post_group |-> (($past(pe_q) | $past(sro_q)) & post_mask) == 8'h00)
    else $error("errored or single-return entry grouped");
  group_irq_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    post_valid && post_group |-> post_irq == girq_on_q
      && {post_irq_level, post_irq_vector} == girq_q)
    else $error("group irq not from init settings");
  lone_irq_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(post_valid) && !post_group |-> post_irq == |($past(irq_allow_q) & post_mask))
    else $error("lone return ignores own irq enable");
  size_pad_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    frm_hit |=> size_q[$past(frm_idx)] == $past(xfer) + `RCM_SIZE_PAD)
    else $error("returned size not transfer plus four");
  own_first_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    frm_hit && (|own_m) |-> !any_q[frm_idx] && port_q[frm_idx] == frame_port)
    else $error("pool buffer used while own port buffer free");
  dma_addr_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    frm_hit && !frame_monitor && !frame_err |=> dma_start && dma_addr == $past(badr_q[frm_idx]))
    else $error("frame not sent to command buffer address");
  post_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    post_valid && !post_ready |=> post_valid && $stable(post_mask))
    else $error("posted completion dropped before taken");
endmodule

// ### rtl/rcm_defs.svh
`ifndef RCM_DEFS_SVH
`define RCM_DEFS_SVH
// Notes on behaviour
// - code 0x60 marks a receive command
// - receive port selector valid only 0..3
// - single-return bit forces individual return
// - any-port buffer serves frames on every port
// - frame data goes to command buffer address
// - returned size is bytes moved plus four
// - monitor mode reports type, moves no data
// - monitor fills source address, normal does not
// - code 0x80 initialises grouped completion
// - several finished commands return as one group
// - never group fewer than two commands
// - failed commands always return alone
// - group uses group irq, not members'
// - lone returns use their own irq fields
// - control bit 0 turns grouping on/off
// - control bit 1 enables group interrupt
// - word 0x07 holds group level and vector
// - minimum group count word is ignored
// - maximum group count caps group size
// - group init reports no specific errors; here a non-master slot returns status 0x0022
// - frame fills buffer, command updated, posted back

// command codes
`define RCM_CODE_RECV   16'h0060
`define RCM_CODE_GINIT  16'h0080
// command block word offsets
`define RCM_W_CODE      5'h00
`define RCM_W_OPT       5'h01
`define RCM_W_NIRQ      5'h03
`define RCM_W_EIRQ      5'h04
`define RCM_W_ADDR_HI   5'h06
`define RCM_W_ADDR_LO   5'h07
`define RCM_W_MAXSZ     5'h09
`define RCM_W_CTRL      5'h06
`define RCM_W_GIRQ      5'h07
`define RCM_W_MINCNT    5'h08
`define RCM_W_MAXCNT    5'h09
`define RCM_W_LAST      5'h11
// option and control bit positions
`define RCM_OPT_IRQ_ALLOW 0
`define RCM_OPT_SRO     7
`define RCM_OPT_PORT_LO 3
`define RCM_OPT_PORT_HI 6
`define RCM_OPT_ANY     15
`define RCM_CTL_GRP     0
`define RCM_CTL_GIRQ    1
// register addresses
`define RCM_REG_SUBMIT  8'h20
`define RCM_REG_STATUS  8'h21
`define RCM_REG_LASTST  8'h22
`define RCM_REG_GCFG    8'h23
`define RCM_REG_DROPS   8'h24
// return status codes
`define RCM_ST_OK       16'h0000
`define RCM_ST_BADCODE  16'h0020
`define RCM_ST_BADPORT  16'h0021
`define RCM_ST_BADSLOT  16'h0022
`define RCM_ST_FULL     16'h0023
`define RCM_ST_FRMERR   16'h0024
// limits and reset values
`define RCM_PORT_MAX    4'h3
`define RCM_SIZE_PAD    16'h0004
`define RCM_ETH_MAX     16'h05ee
`define RCM_MAXCNT_RST  16'h0018
`define RCM_GIRQ_RST    16'h0000
`endif

// ### rtl/rcm_pkg.sv
package rcm_pkg;
  typedef logic [15:0] rcm_word_t;
  typedef logic [7:0]  rcm_addr_t;
  typedef logic [7:0]  rcm_mask_t;
  typedef logic [2:0]  rcm_idx_t;
  typedef enum logic [1:0] {
    RCM_IDLE = 2'b01,
    RCM_HOLD = 2'b10
  } rcm_post_e;
endpackage

// ### sim/rcm_host_tk.sv
`timescale 1ns/1ps
// host side completion taker; stall holds ready low so finished entries pile up
module rcm_host_tk (
  // clock and reset
  input  wire logic               clk_sys,
  input  wire logic               rst_n,
  // control from bench
  input  wire logic               stall,
  // completion port
  input  wire logic               post_valid,
  output logic                    post_ready,
  input  wire logic               post_group,
  input  wire rcm_pkg::rcm_mask_t post_mask,
  input  wire rcm_pkg::rcm_word_t post_status,
  input  wire rcm_pkg::rcm_word_t post_size,
  input  wire rcm_pkg::rcm_word_t post_type,
  input  wire logic [47:0]        post_src,
  input  wire logic               post_irq,
  input  wire logic [7:0]         post_irq_level,
  input  wire logic [7:0]         post_irq_vector
);
  import rcm_pkg::*;
  // one slot per completion taken, read by the bench
  logic [19:0] grp;
  rcm_mask_t   msk [20];
  rcm_word_t   sts [20];
  rcm_word_t   siz [20];
  rcm_word_t   typ [20];
  logic [47:0] src [20];
  logic [16:0] irq [20];
  int          n;
  // ready lags stall by a cycle, like a slow host
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
      post_ready <= 1'b0;
    else
      post_ready <= !stall;
  // a host without the group interrupt polls, so take regardless of irq
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
      n <= 0;
    else if (post_valid && post_ready && n < 20)
    begin
      grp[n] <= post_group;
      msk[n] <= post_mask;
      sts[n] <= post_status;
      siz[n] <= post_size;
      typ[n] <= post_type;
      src[n] <= post_src;
      irq[n] <= {post_irq, post_irq_level, post_irq_vector};
      n      <= n + 1;
    end
endmodule

// ### sim/testbench.sv
`timescale 1ns/1ps
// bench for the command core; the host taker sits on the completion port
module testbench;
  import rcm_pkg::*;
  logic        clk_sys, rst_n, stall, reg_wr, reg_rd, post_valid, post_ready, post_group;
  logic        frame_valid, frame_err, frame_monitor, frame_drop, dma_start, post_irq;
  rcm_addr_t   reg_addr;
  rcm_word_t   reg_wdata, post_status, post_size, post_type, st;
  logic [15:0] reg_rdata, frame_len, frame_type, dma_len;
  logic [1:0]  frame_port;
  logic [47:0] frame_src, post_src;
  logic [31:0] dma_addr;
  rcm_mask_t   post_mask;
  logic [7:0]  post_irq_level, post_irq_vector;
  int          err_count, samples_checked, b;

  rcm_cmd_core dut (.clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .frame_valid, .frame_port, .frame_len, .frame_err, .frame_monitor, .frame_type,
    .frame_src, .frame_drop, .dma_start, .dma_addr, .dma_len, .post_valid, .post_ready,
    .post_group, .post_mask, .post_status, .post_size, .post_type, .post_src, .post_irq,
    .post_irq_level, .post_irq_vector);
  rcm_host_tk tk (.clk_sys, .rst_n, .stall, .post_valid, .post_ready, .post_group,
    .post_mask, .post_status, .post_size, .post_type, .post_src, .post_irq,
    .post_irq_level, .post_irq_vector);

  // free running system clock
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic summarize();
    $display("mismatches %0d comparisons %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one write strobe, then a quiet cycle so the next call never doubles a strobe
  task automatic wr(input rcm_addr_t a, input rcm_word_t d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(input rcm_addr_t a, output rcm_word_t d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic cmd(input rcm_word_t code, opt, input logic [31:0] adr,
                     input rcm_word_t w8, w9, input logic mst);
    wr(8'h00, code);
    wr(8'h01, opt);
    wr(8'h03, 16'h0345);
    wr(8'h04, 16'h0a0b);
    wr(8'h06, adr[31:16]);
    wr(8'h07, adr[15:0]);
    wr(8'h08, w8);
    wr(8'h09, w9);
    wr(8'h20, {15'h0000, mst});
    rd(8'h22, st);
  endtask

  task automatic rx(input rcm_word_t opt, input logic [31:0] adr, input rcm_word_t mx);
    cmd(16'h0060, opt, adr, 16'h0000, mx, 1'b1);
    chk("rx status", st, 16'h0000);
  endtask

  task automatic gi(input rcm_word_t ctl, gq, mn, mx);
    cmd(16'h0080, 16'h0000, {ctl, gq}, mn, mx, 1'b1);
    chk("init status", st, 16'h0000);
  endtask

  // outputs of the frame answer are settled when this returns
  task automatic frm(input logic [1:0] p, input rcm_word_t len, input logic e, m);
    @(posedge clk_sys);
    frame_port    <= p;
    frame_len     <= len;
    frame_err     <= e;
    frame_monitor <= m;
    frame_type    <= 16'h0800;
    frame_src     <= 48'h0a1b2c3d4e5f;
    frame_valid   <= 1'b1;
    @(posedge clk_sys);
    frame_valid   <= 1'b0;
    #1;
  endtask

  task automatic wt(input int k);
    for (int i = 0; i < 300 && tk.n < k; i++)
      @(posedge clk_sys);
    if (tk.n < k)
    begin
      err_count++;
      $display("[FAIL] posts expected %0d seen %0d", k, tk.n);
      summarize();
    end
  endtask

  task automatic t_reset();
    rd(8'h23, st);
    chk("gcfg reset", st, 16'h0000);
    rd(8'h30, st);
    chk("unmapped", st, 16'h0000);
  endtask

  task automatic t_refuse();
    cmd(16'h0055, 16'h0000, 32'h0, 16'h0000, 16'h05ee, 1'b1);
    chk("bad code", st, 16'h0020);
    cmd(16'h0060, 16'h0020, 32'h0, 16'h0000, 16'h05ee, 1'b1);
    chk("bad port", st, 16'h0021);
    cmd(16'h0080, 16'h0000, 32'h00030000, 16'h0000, 16'h0018, 1'b0);
    chk("init slot", st, 16'h0022);
    rd(8'h21, st);
    chk("pool empty", st, 16'h0000);
  endtask

  task automatic t_single();
    b = tk.n;
    rx(16'h0009, 32'h12345678, 16'h05ee);
    frm(2'd1, 16'h0040, 1'b0, 1'b0);
    chk("dma start", dma_start, 1'b1);
    chk("dma addr", dma_addr, 32'h12345678);
    chk("dma len", dma_len, 16'h0040);
    rx(16'h0009, 32'h00002000, 16'h0020);
    frm(2'd1, 16'h0040, 1'b0, 1'b0);
    chk("dma clip", dma_len, 16'h0020);
    rx(16'h0009, 32'h00003000, 16'h05ee);
    frm(2'd1, 16'h0064, 1'b1, 1'b0);
    chk("err no dma", dma_start, 1'b0);
    rx(16'h0008, 32'h00004000, 16'h05ee);
    frm(2'd1, 16'h003c, 1'b0, 1'b1);
    chk("mon no dma", dma_start, 1'b0);
    wt(b + 4);
    chk("size", tk.siz[b], 16'h0044);
    chk("irq own", tk.irq[b], 17'h10345);
    chk("type idle", tk.typ[b], 16'h0000);
    chk("src idle", tk.src[b], 48'h0);
    chk("size clip", tk.siz[b+1], 16'h0024);
    chk("err status", tk.sts[b+2], 16'h0024);
    chk("err irq", tk.irq[b+2], 17'h10a0b);
    chk("mon type", tk.typ[b+3], 16'h0800);
    chk("mon src", tk.src[b+3], 48'h0a1b2c3d4e5f);
    chk("mon no irq", tk.irq[b+3][16], 1'b0);
    frm(2'd2, 16'h0040, 1'b0, 1'b0);
    chk("drop", frame_drop, 1'b1);
    rd(8'h24, st);
    chk("drop count", st, 16'h0001);
  endtask

  task automatic t_port();
    b = tk.n;
    rx(16'h8000, 32'h0000a000, 16'h05ee);
    rx(16'h0018, 32'h0000b000, 16'h05ee);
    frm(2'd3, 16'h0040, 1'b0, 1'b0);
    chk("own port", dma_addr, 32'h0000b000);
    frm(2'd0, 16'h0040, 1'b0, 1'b0);
    chk("any port", dma_addr, 32'h0000a000);
    wt(b + 2);
  endtask

  task automatic t_group();
    gi(16'h0003, 16'h0507, 16'h0009, 16'h0002);
    rd(8'h23, st);
    chk("gcfg on", st, 16'h0003);
    stall <= 1'b1;
    b = tk.n;
    repeat (4) rx(16'h8000, 32'h0000c000, 16'h05ee);
    rx(16'h8080, 32'h0000d000, 16'h05ee);
    repeat (5) frm(2'd2, 16'h0040, 1'b0, 1'b0);
    stall <= 1'b0;
    wt(b + 4);
    chk("lone", {tk.grp[b], tk.msk[b]}, 9'h001);
    chk("group", {tk.grp[b+1], tk.msk[b+1]}, 9'h106);
    chk("group count", tk.siz[b+1], 16'h0002);
    chk("group irq", tk.irq[b+1], 17'h10507);
    chk("rest alone", {tk.grp[b+2], tk.grp[b+3]}, 2'b00);
    chk("rest mask", tk.msk[b+2] | tk.msk[b+3], 8'h18);
  endtask

  task automatic t_noirq();
    gi(16'h0001, 16'h0507, 16'h0000, 16'h0018);
    stall <= 1'b1;
    b = tk.n;
    repeat (3) rx(16'h8001, 32'h0000e000, 16'h05ee);
    repeat (3) frm(2'd0, 16'h0040, 1'b0, 1'b0);
    stall <= 1'b0;
    wt(b + 2);
    chk("lone irq", tk.irq[b], 17'h10345);
    chk("group mask", {tk.grp[b+1], tk.msk[b+1]}, 9'h106);
    chk("group no irq", tk.irq[b+1][16], 1'b0);
    gi(16'h0000, 16'h0507, 16'h0000, 16'h0018);
    rd(8'h23, st);
    chk("gcfg off", st, 16'h0000);
    stall <= 1'b1;
    b = tk.n;
    repeat (2) rx(16'h8000, 32'h0000f000, 16'h05ee);
    repeat (2) frm(2'd1, 16'h0040, 1'b0, 1'b0);
    stall <= 1'b0;
    wt(b + 2);
    chk("off single", {tk.grp[b], tk.grp[b+1]}, 2'b00);
    // a cap of one must still drain a pile of eligible entries one by one
    gi(16'h0001, 16'h0507, 16'h0000, 16'h0001);
    stall <= 1'b1;
    b = tk.n;
    repeat (3) rx(16'h8000, 32'h0000f100, 16'h05ee);
    repeat (3) frm(2'd1, 16'h0040, 1'b0, 1'b0);
    stall <= 1'b0;
    wt(b + 3);
    chk("cap one", {tk.grp[b], tk.grp[b+1], tk.grp[b+2]}, 3'b000);
  endtask

  // reset held four cycles, then the scenarios in turn
  initial
  begin
    rst_n = 1'b0;
    stall = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    frame_valid = 1'b0;
    frame_port = 2'd0;
    frame_len = 16'h0000;
    frame_err = 1'b0;
    frame_monitor = 1'b0;
    frame_type = 16'h0000;
    frame_src = 48'h0;
    err_count = 0;
    samples_checked = 0;
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_reset();
    t_refuse();
    t_single();
    t_port();
    t_group();
    t_noirq();
    summarize();
  end
endmodule
